// file: src/flash_program_erase_protect.sv
// Flash program/erase sequencer with block protection, APB register slave.
// Assumes the array storage sits outside and acts on the program strobe
// and the erase select outputs while high voltage is on.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_protect
    import flash_ctl_pkg::*;
#(
    parameter logic [7:0] PROTECT_INIT = PROTECT_NONE
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic test_high_voltage,
    output logic high_voltage_enable,
    output logic program_select,
    output logic erase_select,
    output logic mass_select,
    output logic program_strobe,
    output logic [15:0] program_addr,
    output logic [7:0] program_data,
    output logic array_ready
);
    import flash_ctl_pkg::*;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic pgm_reg, erase_reg, mass_reg, hv_reg;
    logic prot_read_reg, armed_reg, refused_reg;
    logic [7:0] protect_reg;
    logic [15:0] target_reg;
    logic tst_meta_reg, tst_reg;
    logic [7:0] rcv_cnt_reg;
    logic strobe_reg, ready_reg, pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic [15:0] paddr_reg, pdata_reg;

    wire setup = psel && !penable;
    wire commit = psel && penable && pready_reg;
    wire sel_ctrl = paddr == CTRL_OFFSET;
    wire sel_prot = paddr == PROTECT_OFFSET;
    wire sel_stat = paddr == STATUS_OFFSET;
    wire sel_array = paddr[31:16] == ARRAY_BASE_HI;
    wire mapped = sel_ctrl || sel_prot || sel_stat || (sel_array && pwrite);
    wire ctrl_wr = commit && pwrite && sel_ctrl;
    wire prot_rd = commit && !pwrite && sel_prot;
    wire array_wr = commit && pwrite && sel_array;
    wire [15:0] arr_addr = paddr[15:0];

    // ------------------------------------------------------------------
    // Protected range
    // ------------------------------------------------------------------
    // Start address built from the stored protect bits
    wire [15:0] prot_start = {PROTECT_TOP_BITS, protect_reg, PROTECT_LOW_BITS};
    wire unlocked = protect_reg == PROTECT_NONE;

    function automatic logic is_prot(input logic [15:0] a);
        logic hit;
        hit = (protect_reg == PROTECT_ALL) || (a >= prot_start)
            || (a >= ALWAYS_PROT_LO && a <= ALWAYS_PROT_HI)
            || (a == PROTECT_BYTE_ADDR);
        return !unlocked && !tst_reg && hit;
    endfunction

    // Erase of a page or the whole array covering the target
    wire page_has_pbyte = target_reg[15:PAGE_BITS] == PROTECT_BYTE_ADDR[15:PAGE_BITS];
    wire erase_prot = mass_reg ? (!unlocked && !tst_reg) : is_prot(target_reg);
    wire target_prot = pgm_reg ? is_prot(target_reg) : erase_prot;

    // ------------------------------------------------------------------
    // Control register next state
    // ------------------------------------------------------------------
    wire w_pgm = pwdata[CTRL_PGM_BIT];
    wire w_erase = pwdata[CTRL_ERASE_BIT];
    wire w_hv = pwdata[CTRL_HV_BIT];
    wire clash = w_pgm && w_erase;
    // A write asking for both keeps the old selection
    wire pgm_next = ctrl_wr ? (clash ? pgm_reg : w_pgm) : pgm_reg;
    wire erase_next = ctrl_wr ? (clash ? erase_reg : w_erase) : erase_reg;
    wire mass_next = ctrl_wr ? pwdata[CTRL_MASS_BIT] : mass_reg;
    wire new_mode = (pgm_next && !pgm_reg) || (erase_next && !erase_reg);
    wire no_mode = !pgm_next && !erase_next;
    // High voltage needs one mode, the read, the latching write, free target
    wire hv_ok = (pgm_reg ^ erase_reg) && (pgm_next ^ erase_next) && armed_reg
        && !target_prot;
    wire hv_req = ctrl_wr && w_hv && !hv_reg;
    wire hv_next = ctrl_wr ? (w_hv && (hv_reg || hv_ok)) : hv_reg;
    wire hv_rise = hv_next && !hv_reg;

    // Latching write: first array write after the protect read
    wire arm_wr = array_wr && (pgm_reg || erase_reg) && prot_read_reg && !hv_reg
        && !armed_reg;
    // Byte programming confined to the latched row
    wire in_row = arr_addr[15:ROW_BITS] == target_reg[15:ROW_BITS];
    wire byte_wr = array_wr && pgm_reg && hv_reg && in_row && !is_prot(arr_addr);

    // Protect byte changes only by programming or erase with HV
    wire pbyte_prog = byte_wr && arr_addr == PROTECT_BYTE_ADDR;
    wire pbyte_erase = hv_rise && erase_reg && (mass_reg || page_has_pbyte);
    wire [7:0] protect_next = pbyte_erase ? PROTECT_NONE
        : pbyte_prog ? (protect_reg & pwdata[7:0]) : protect_reg;

    wire [31:0] ctrl_val = 32'(({hv_reg, mass_reg, erase_reg, pgm_reg}));
    wire [31:0] stat_val = 32'({ready_reg, refused_reg, armed_reg, prot_read_reg});
    wire [31:0] rd_val = sel_ctrl ? ctrl_val : sel_prot ? 32'(protect_reg)
        : sel_stat ? stat_val : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        tst_meta_reg <= test_high_voltage;
        tst_reg <= tst_meta_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            // No wait state: answer in the first access cycle
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            prdata_reg <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pgm_reg <= 1'b0;
            erase_reg <= 1'b0;
            mass_reg <= 1'b0;
            hv_reg <= 1'b0;
        end else begin
            pgm_reg <= pgm_next;
            erase_reg <= erase_next;
            mass_reg <= mass_next;
            hv_reg <= hv_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prot_read_reg <= 1'b0;
            armed_reg <= 1'b0;
            target_reg <= 16'h0000;
        end else begin
            // A fresh mode select restarts the read-then-latch order
            prot_read_reg <= !(new_mode || no_mode) && (prot_read_reg || prot_rd);
            armed_reg <= !(new_mode || no_mode) && (armed_reg || arm_wr);
            if (arm_wr) begin
                target_reg <= arr_addr;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            refused_reg <= 1'b0;
        end else begin
            // Refusal sticks until the next mode select; refusal wins
            refused_reg <= (hv_req && w_hv && !hv_ok) || (refused_reg && !new_mode);
        end
    end

    // Non-volatile byte: a reset keeps its contents, only the first load
    // Power-up value stands in for retained state; without it the load never fires
    logic pinit_reg = 1'b0;
    always_ff @(posedge clk_sys) begin
        if (rst && !pinit_reg) begin
            protect_reg <= PROTECT_INIT;
            pinit_reg <= 1'b1;
        end else begin
            protect_reg <= protect_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strobe_reg <= 1'b0;
            paddr_reg <= 16'h0000;
            pdata_reg <= 16'h0000;
        end else begin
            strobe_reg <= byte_wr;
            if (byte_wr) begin
                paddr_reg <= arr_addr;
                pdata_reg <= 16'(pwdata[7:0]);
            end
        end
    end

    // Array unreadable while HV is on and for the recovery time after
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rcv_cnt_reg <= 8'h00;
            ready_reg <= 1'b1;
        end else if (hv_reg) begin
            rcv_cnt_reg <= 8'(READ_RECOVERY_CYCLES);
            ready_reg <= 1'b0;
        end else begin
            rcv_cnt_reg <= (rcv_cnt_reg == 8'h00) ? 8'h00 : rcv_cnt_reg - 8'h01;
            ready_reg <= rcv_cnt_reg <= 8'h01;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign high_voltage_enable = hv_reg;
    assign program_select = pgm_reg;
    assign erase_select = erase_reg;
    assign mass_select = mass_reg;
    assign program_strobe = strobe_reg;
    assign program_addr = paddr_reg;
    assign program_data = pdata_reg[7:0];
    assign array_ready = ready_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_never_both;
        !(pgm_reg && erase_reg);
    endproperty
    a_never_both: assert property (p_never_both) else $error("both modes");
    property p_hv_one_mode;
        $rose(hv_reg) |-> (pgm_reg ^ erase_reg) && $past(armed_reg);
    endproperty
    a_hv_one_mode: assert property (p_hv_one_mode) else $error("hv bad mode");
    property p_hv_unprot;
        $rose(hv_reg) |-> !$past(target_prot);
    endproperty
    a_hv_unprot: assert property (p_hv_unprot) else $error("hv protected");
    property p_all_zero;
        (protect_reg == PROTECT_ALL && !tst_reg && pgm_reg) |-> is_prot(target_reg);
    endproperty
    a_all_zero: assert property (p_all_zero) else $error("zero not all");
    property p_start;
        prot_start[15:14] == 2'b11 && prot_start[5:0] == 6'h00
            && prot_start[13:6] == protect_reg;
    endproperty
    a_start: assert property (p_start) else $error("start addr");
    property p_fixed_block;
        (!unlocked && !tst_reg) |-> is_prot(ALWAYS_PROT_LO) && is_prot(ALWAYS_PROT_HI);
    endproperty
    a_fixed_block: assert property (p_fixed_block) else $error("block open");
    property p_row;
        program_strobe |-> program_addr[15:5] == target_reg[15:5] && pgm_reg;
    endproperty
    a_row: assert property (p_row) else $error("outside row");
    property p_arm_after_read;
        $rose(armed_reg) |-> $past(prot_read_reg) && $past(array_wr);
    endproperty
    a_arm_after_read: assert property (p_arm_after_read) else $error("latch order");
    property p_pbyte_stable;
        !$stable(protect_reg) |-> ($past(hv_reg) || $past(hv_next))
            && !($past(ctrl_wr) && !$past(hv_next));
    endproperty
    a_pbyte_stable: assert property (p_pbyte_stable) else $error("pbyte write");
    property p_pbyte_lock;
        (pbyte_prog && !tst_reg) |-> unlocked;
    endproperty
    a_pbyte_lock: assert property (p_pbyte_lock) else $error("pbyte locked");

    c_hv_on: cover property ($rose(hv_reg) && pgm_reg);
    c_mass: cover property ($rose(hv_reg) && erase_reg && mass_reg);
    c_refused: cover property ($rose(refused_reg));
    c_strobe: cover property (program_strobe);
endmodule
`default_nettype wire

// file: src/flash_ctl_pkg.sv
// Package for the flash program / erase / block protection controller.
// Assumes a 200 MHz system clock and 32-bit APB register access.
package flash_ctl_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] PROTECT_OFFSET = 32'h0000_0004;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0008;
    // Array window: byte address = ARRAY_BASE + 16-bit array address
    localparam logic [15:0] ARRAY_BASE_HI = 16'h0001;
    // ------------------------------------------------------------------
    // Control and status bit positions
    // ------------------------------------------------------------------
    localparam int CTRL_PGM_BIT = 0;
    localparam int CTRL_ERASE_BIT = 1;
    localparam int CTRL_MASS_BIT = 2;
    localparam int CTRL_HV_BIT = 3;
    localparam int STAT_PROT_READ_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int STAT_READY_BIT = 3;
    // ------------------------------------------------------------------
    // Protection layout
    // ------------------------------------------------------------------
    localparam logic [7:0] PROTECT_NONE = 8'hff;
    localparam logic [7:0] PROTECT_ALL = 8'h00;
    localparam logic [1:0] PROTECT_TOP_BITS = 2'b11;
    localparam logic [5:0] PROTECT_LOW_BITS = 6'h00;
    localparam logic [15:0] ALWAYS_PROT_LO = 16'hbc00;
    localparam logic [15:0] ALWAYS_PROT_HI = 16'hbfff;
    localparam logic [15:0] PROTECT_BYTE_ADDR = 16'hffde;
    localparam int ROW_BITS = 5;
    localparam int PAGE_BITS = 6;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int READ_RECOVERY_DELAY_US = 1;
    localparam int READ_RECOVERY_CYCLES =
        (READ_RECOVERY_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// file: tb/flash_program_erase_protect_tb.sv
// Self-checking bench for the flash program / erase / protect sequencer.
// Assumes the package register map and the zero-wait-state APB slave; no array model.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_protect_tb;
    import flash_ctl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic test_high_voltage = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, high_voltage_enable, program_select, erase_select, mass_select;
    logic program_strobe, array_ready;
    logic [15:0] program_addr;
    logic [7:0] program_data;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int n_tests = 0;
    int n_strobe = 0;
    int cyc = 0;
    logic [15:0] tgt [5] = '{16'hc040, 16'hc020, 16'hbc00, 16'hffde, 16'hffc0};
    logic ok_tab [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

    flash_program_erase_protect i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .test_high_voltage(test_high_voltage), .high_voltage_enable(high_voltage_enable),
        .program_select(program_select), .erase_select(erase_select),
        .mass_select(mass_select), .program_strobe(program_strobe),
        .program_addr(program_addr), .program_data(program_data),
        .array_ready(array_ready));

    always #2.5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // Strobe counter and hang guard
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (program_strobe === 1'b1) begin
            n_strobe <= n_strobe + 1;
        end
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            $display("[ERR] %0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Full program or erase sequence; ok says whether HV must be granted
    // ----------------------------------------------------------------
    task automatic seq(input logic [3:0] mode, input logic [15:0] a, input logic [7:0] d,
                       input logic ok);
        int s;
        int n;
        apb(1'b1, CTRL_OFFSET, {28'h0, mode});
        @(negedge clk_sys);
        chk(32'(program_select), 32'(mode[CTRL_PGM_BIT]));
        chk(32'(erase_select), 32'(mode[CTRL_ERASE_BIT]));
        chk(32'(mass_select), 32'(mode[CTRL_MASS_BIT]));
        apb(1'b0, PROTECT_OFFSET, 32'h0);
        apb(1'b1, {ARRAY_BASE_HI, a}, 32'h0);
        apb(1'b1, CTRL_OFFSET, {28'h0, mode | 4'h8});
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(32'(rd[CTRL_HV_BIT]), 32'(ok));
        chk(32'(high_voltage_enable), 32'(ok));
        if (ok) begin
            s = n_strobe;
            if (mode[CTRL_PGM_BIT]) begin
                // Row end first: the protect byte locks its own row once written
                apb(1'b1, {ARRAY_BASE_HI, a | 16'h001f}, {24'h0, d});
                apb(1'b1, {ARRAY_BASE_HI, a}, {24'h0, d});
                // Next row over: must not be programmed under this latch
                apb(1'b1, {ARRAY_BASE_HI, a + 16'h0020}, 32'h0);
                repeat (2) @(negedge clk_sys);
                chk(n_strobe - s, 2);
                chk({16'h0, program_addr}, {16'h0, a});
                chk({24'h0, program_data}, {24'h0, d});
            end
            apb(1'b1, CTRL_OFFSET, {28'h0, (mode & 4'h4) | 4'h8});
            apb(1'b1, CTRL_OFFSET, 32'h0);
            @(negedge clk_sys);
            chk(32'(array_ready), 32'h0);
            n = 0;
            while (array_ready !== 1'b1 && n < 400) begin
                @(negedge clk_sys);
                n++;
            end
            chk(32'(n > READ_RECOVERY_CYCLES - 5 && n < READ_RECOVERY_CYCLES + 5), 1);
        end else begin
            apb(1'b0, STATUS_OFFSET, 32'h0);
            chk(32'(rd[STAT_REFUSED_BIT]), 32'h1);
            apb(1'b1, CTRL_OFFSET, 32'h0);
        end
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h8);
        apb(1'b0, PROTECT_OFFSET, 32'h0);
        chk(rd, 32'hff);
        apb(1'b1, PROTECT_OFFSET, 32'h0);
        apb(1'b0, PROTECT_OFFSET, 32'h0);
        chk(rd, 32'hff);
        apb(1'b0, 32'h0000_000c, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, CTRL_OFFSET, 32'h3);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        // HV request with the protect read skipped must be refused
        apb(1'b1, CTRL_OFFSET, 32'h1);
        apb(1'b1, {ARRAY_BASE_HI, 16'hc000}, 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h9);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(32'(rd[CTRL_HV_BIT]), 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h0);
        seq(4'h1, 16'hbc00, 8'h5a, 1'b1);
        seq(4'h1, 16'hffde, 8'h00, 1'b1);
        apb(1'b0, PROTECT_OFFSET, 32'h0);
        chk(rd, 32'h0);
        seq(4'h1, 16'hc000, 8'h11, 1'b0);
        seq(4'h6, 16'hc000, 8'h00, 1'b0);
        test_high_voltage <= 1'b1;
        repeat (4) @(posedge clk_sys);
        seq(4'h6, 16'hc000, 8'h00, 1'b1);
        test_high_voltage <= 1'b0;
        repeat (4) @(posedge clk_sys);
        apb(1'b0, PROTECT_OFFSET, 32'h0);
        chk(rd, 32'hff);
        // Start address becomes 0xc040 with protect value 0x01
        seq(4'h1, 16'hffde, 8'h01, 1'b1);
        for (int i = 0; i < 5; i++) begin
            seq(4'h1, tgt[i], 8'ha5, ok_tab[i]);
        end
        complete_run();
    end
endmodule
`default_nettype wire
